/* idf_chan.sv */
// one debounce channel: saturating up/down counter with threshold
`timescale 1ns/1ps
`default_nettype none
module idf_chan
(
  input wire logic core_clk_in,
  input wire logic sys_rst_in,
  input wire logic tick_in,
  input wire logic raw_in,
  input wire logic [15:0] setting_in,
  output logic state_out
);
  logic [15:0] cnt_ff;
  logic [15:0] nxt_cnt;
  logic filt_ff;
  logic nxt_filt;
  wire bypass = (setting_in == 16'h0000);
  wire at_top = (cnt_ff >= setting_in);
  wire at_zero = (cnt_ff == 16'h0000);

  // saturating count; clamp when threshold lowered below count
  assign nxt_cnt = bypass ? 16'h0000 :
    raw_in ? (at_top ? setting_in : cnt_ff + 16'h0001) :
    (at_zero ? 16'h0000 : (at_top ? setting_in - 16'h0001 : cnt_ff - 16'h0001));
  // threshold reached sets, zero clears, otherwise hold
  assign nxt_filt = (nxt_cnt == setting_in) ? 1'b1 :
    (nxt_cnt == 16'h0000) ? 1'b0 : filt_ff;

  always_ff @(posedge core_clk_in or posedge sys_rst_in)
  begin
    if (sys_rst_in)
    begin
      cnt_ff <= 16'h0000;
      filt_ff <= 1'b0;
    end
    else if (tick_in)
    begin
      cnt_ff <= nxt_cnt;
      filt_ff <= bypass ? raw_in : nxt_filt;
    end
  end

  // bypass still tracks raw so re-enable starts from a sane state
  assign state_out = bypass ? raw_in : filt_ff;

  // checked after each non-bypass tick: a lowered threshold clamps on the next tick, not at once
  a_cnt_bound: assert property (@(posedge core_clk_in) disable iff (sys_rst_in)
    (tick_in && !bypass) |=> (cnt_ff <= $past(setting_in)))
    else $error("counter above threshold");
  a_filt_high: assert property (@(posedge core_clk_in) disable iff (sys_rst_in)
    (tick_in && !bypass && nxt_cnt == setting_in) |=> filt_ff)
    else $error("state not set at threshold");
  a_filt_low: assert property (@(posedge core_clk_in) disable iff (sys_rst_in)
    (tick_in && !bypass && nxt_cnt == 16'h0000) |=> !filt_ff)
    else $error("state not cleared at zero");
  a_filt_hold: assert property (@(posedge core_clk_in) disable iff (sys_rst_in)
    !tick_in |=> $stable(filt_ff))
    else $error("state moved without tick");
endmodule : idf_chan
`default_nettype wire

/* idf_pkg.sv */
// package for the input debounce filter: constants and carrier types
package idf_pkg;
  localparam int unsigned IDF_NUM_INPUTS = 8;
  localparam int unsigned IDF_SET_W = 16;
  localparam int unsigned IDF_SEL_W = 3;
  localparam int unsigned IDF_CLK_MHZ = 250;
  localparam int unsigned IDF_TICK_SERVO_US = 125;
  localparam int unsigned IDF_TICK_OTHER_US = 100;
  localparam int unsigned IDF_TICK_SERVO_CYC = IDF_TICK_SERVO_US * IDF_CLK_MHZ;
  localparam int unsigned IDF_TICK_OTHER_CYC = IDF_TICK_OTHER_US * IDF_CLK_MHZ;
  localparam int unsigned IDF_DIV_W = 15;
  localparam logic [15:0] IDF_SET_RST = 16'h0000;

  typedef struct packed {
    logic wr;
    logic [2:0] sel;
    logic [15:0] value;
  } idf_set_wr_t;

  typedef struct packed {
    logic start;
    logic [2:0] sel;
    logic level;
  } idf_wait_cmd_t;

  typedef enum logic [1:0] {
    IDF_W_IDLE = 2'b01,
    IDF_W_BUSY = 2'b10
  } idf_wait_st_t;
endpackage : idf_pkg

/* idf_switch_model.sv */
// switch model: raw input pins with contact bounce after each change
`timescale 1ns/1ps
`default_nettype none
module idf_switch_model
(
  input wire logic core_clk_in,
  input wire logic [7:0] level_in,
  output logic [7:0] pin_out
);
  logic [7:0] prev_ff = 8'h00;
  logic [7:0] chg_ff = 8'h00;
  logic [3:0] bounce_ff = 4'h0;
  // chatter is short against a tick, so it only stresses the synchroniser
  always @(posedge core_clk_in)
  begin
    prev_ff <= level_in;
    if (prev_ff != level_in)
    begin
      bounce_ff <= 4'h7;
      chg_ff <= prev_ff ^ level_in;
    end
    else if (bounce_ff != 4'h0)
      bounce_ff <= bounce_ff - 4'h1;
  end
  // high means open, low means closed
  // only the pins that changed chatter
  assign pin_out = bounce_ff[0] ? (level_in ^ chg_ff) : level_in;
endmodule : idf_switch_model
`default_nettype wire

/* idf_top.sv */
// input debounce filter top: tick divider, settings, channels, wait command
// Functional notes
// - each selected input has its own threshold setting and counter.
// - each tick, counter rises when raw high, falls when raw low.
// - threshold equals programmed setting in ticks.
// - state goes high at threshold, low at zero, else holds.
// - setting zero bypasses filter; raw level passes straight through.
// - tick period is 125 us for servo variants, else 100 us.
// - reset leaves every filter disabled.
// - read and wait commands see only the filtered state.
// - wait completes at once when filtered state already matches.
// - clean change appears exactly threshold ticks after raw change.
// - filter averages; noise drifts toward majority and lengthens lag.
// - settings persist after save, unless variant is volatile.
`timescale 1ns/1ps
`default_nettype none
module idf_top
(
  input wire logic core_clk_in,
  input wire logic sys_rst_in,
  input wire logic servo_variant_in,
  input wire logic volatile_variant_in,
  input wire logic [7:0] raw_pins_in,
  input wire idf_pkg::idf_set_wr_t set_wr_in,
  input wire logic [2:0] rd_sel_in,
  output logic [15:0] rd_setting_out,
  output logic [7:0] filt_state_out,
  input wire logic save_settings_cmd_in,
  output logic save_req_out,
  output logic [127:0] save_data_out,
  input wire logic restore_valid_in,
  input wire logic [127:0] restore_data_in,
  input wire idf_pkg::idf_wait_cmd_t wait_input_level_cmd_in,
  output logic wait_busy_out,
  output logic wait_done_out
);
  logic [7:0] raw_s1_ff;
  logic [7:0] raw_s2_ff;
  logic [14:0] div_ff;
  logic tick_ff;
  logic [15:0] set_ff [8];
  logic [15:0] rd_ff;
  logic [7:0] filt_w;
  logic save_ff;
  logic [127:0] save_data_ff;
  logic done_ff;
  idf_pkg::idf_wait_st_t wst_ff;
  logic [2:0] wsel_ff;
  logic wlvl_ff;

  always_ff @(posedge core_clk_in or posedge sys_rst_in)
  begin
    if (sys_rst_in)
    begin
      raw_s1_ff <= 8'h00;
      raw_s2_ff <= 8'h00;
    end
    else
    begin
      raw_s1_ff <= raw_pins_in;
      raw_s2_ff <= raw_s1_ff;
    end
  end

  // tick period chosen per variant
  wire [14:0] div_last = servo_variant_in ?
    15'(idf_pkg::IDF_TICK_SERVO_CYC - 1) : 15'(idf_pkg::IDF_TICK_OTHER_CYC - 1);
  wire div_wrap = (div_ff >= div_last);

  always_ff @(posedge core_clk_in or posedge sys_rst_in)
  begin
    if (sys_rst_in)
    begin
      div_ff <= 15'h0000;
      tick_ff <= 1'b0;
    end
    else
    begin
      div_ff <= div_wrap ? 15'h0000 : div_ff + 15'h0001;
      tick_ff <= div_wrap;
    end
  end

  // settings: reset disables all; restore reloads only on non-volatile variants
  wire restore_ok = restore_valid_in && !volatile_variant_in;
  always_ff @(posedge core_clk_in or posedge sys_rst_in)
  begin
    if (sys_rst_in)
    begin
      for (int i = 0; i < 8; i++)
      begin
        set_ff[i] <= idf_pkg::IDF_SET_RST;
      end
    end
    else if (restore_ok)
    begin
      for (int i = 0; i < 8; i++)
      begin
        set_ff[i] <= restore_data_in[i*16 +: 16];
      end
    end
    else if (set_wr_in.wr)
    begin
      set_ff[set_wr_in.sel] <= set_wr_in.value;
    end
  end

  always_ff @(posedge core_clk_in or posedge sys_rst_in)
  begin
    if (sys_rst_in)
    begin
      rd_ff <= 16'h0000;
    end
    else
    begin
      rd_ff <= set_ff[rd_sel_in];
    end
  end
  assign rd_setting_out = rd_ff;

  // save snapshot goes to external non-volatile store
  always_ff @(posedge core_clk_in or posedge sys_rst_in)
  begin
    if (sys_rst_in)
    begin
      save_ff <= 1'b0;
      save_data_ff <= 128'h0;
    end
    else
    begin
      save_ff <= save_settings_cmd_in && !volatile_variant_in;
      if (save_settings_cmd_in)
      begin
        for (int i = 0; i < 8; i++)
        begin
          save_data_ff[i*16 +: 16] <= set_ff[i];
        end
      end
    end
  end
  assign save_req_out = save_ff;
  assign save_data_out = save_data_ff;

  for (genvar g = 0; g < 8; g++)
  begin : g_chan
    idf_chan u_chan
    (
      .core_clk_in(core_clk_in),
      .sys_rst_in(sys_rst_in),
      .tick_in(tick_ff),
      .raw_in(raw_s2_ff[g]),
      .setting_in(set_ff[g]),
      .state_out(filt_w[g])
    );
  end
  assign filt_state_out = filt_w;

  // wait command: compares against filtered state only
  wire start_match = filt_w[wait_input_level_cmd_in.sel] == wait_input_level_cmd_in.level;
  wire busy_match = filt_w[wsel_ff] == wlvl_ff;

  always_ff @(posedge core_clk_in or posedge sys_rst_in)
  begin
    if (sys_rst_in)
    begin
      wst_ff <= idf_pkg::IDF_W_IDLE;
      wsel_ff <= 3'h0;
      wlvl_ff <= 1'b0;
      done_ff <= 1'b0;
    end
    else
    begin
      done_ff <= 1'b0;
      unique case (wst_ff)
        idf_pkg::IDF_W_IDLE:
        begin
          if (wait_input_level_cmd_in.start)
          begin
            wsel_ff <= wait_input_level_cmd_in.sel;
            wlvl_ff <= wait_input_level_cmd_in.level;
            if (start_match)
            begin
              done_ff <= 1'b1;
            end
            else
            begin
              wst_ff <= idf_pkg::IDF_W_BUSY;
            end
          end
        end
        idf_pkg::IDF_W_BUSY:
        begin
          if (busy_match)
          begin
            done_ff <= 1'b1;
            wst_ff <= idf_pkg::IDF_W_IDLE;
          end
        end
        default:
        begin
          wst_ff <= idf_pkg::IDF_W_IDLE;
        end
      endcase
    end
  end
  assign wait_done_out = done_ff;
  assign wait_busy_out = (wst_ff == idf_pkg::IDF_W_BUSY);

  a_wait_fast: assert property (@(posedge core_clk_in) disable iff (sys_rst_in)
    (wst_ff == idf_pkg::IDF_W_IDLE && wait_input_level_cmd_in.start && start_match)
    |=> (done_ff && wst_ff == idf_pkg::IDF_W_IDLE))
    else $error("matching wait not done at once");
  a_wait_filt: assert property (@(posedge core_clk_in) disable iff (sys_rst_in)
    (wst_ff == idf_pkg::IDF_W_BUSY && busy_match) |=> done_ff)
    else $error("wait missed filtered match");
  a_tick_gap: assert property (@(posedge core_clk_in) disable iff (sys_rst_in)
    tick_ff |=> !tick_ff [*8])
    else $error("ticks too close");
  a_save_vol: assert property (@(posedge core_clk_in) disable iff (sys_rst_in)
    (save_settings_cmd_in && volatile_variant_in) |=> !save_req_out)
    else $error("volatile variant saved");
  a_rd_back: assert property (@(posedge core_clk_in) disable iff (sys_rst_in)
    (set_wr_in.wr && !restore_ok) ##1 (rd_sel_in == $past(set_wr_in.sel))
    |=> rd_setting_out == $past(set_wr_in.value, 2))
    else $error("setting not read back");
endmodule : idf_top
`default_nettype wire

/* tb.sv */
// testbench for the input debounce filter
`timescale 1ns/1ps
`default_nettype none
module tb;
  logic core_clk_in;
  logic sys_rst_in;
  logic [7:0] level;
  logic [7:0] raw_pins;
  idf_pkg::idf_set_wr_t set_wr;
  idf_pkg::idf_wait_cmd_t wait_cmd;
  logic [2:0] rd_sel;
  logic [15:0] rd_setting;
  logic [7:0] filt;
  logic save_cmd;
  logic save_req;
  logic [127:0] save_data;
  logic wait_busy;
  logic wait_done;
  logic servo_var;
  logic volatile_var;
  logic restore_valid;
  logic [127:0] restore_data;
  int n_mismatch = 0;
  int compares = 0;
  int cyc;
  idf_switch_model u_idf_switch_model (.core_clk_in(core_clk_in), .level_in(level),
    .pin_out(raw_pins));
  idf_top u_idf_top (.core_clk_in(core_clk_in), .sys_rst_in(sys_rst_in),
    .servo_variant_in(servo_var), .volatile_variant_in(volatile_var), .raw_pins_in(raw_pins),
    .set_wr_in(set_wr), .rd_sel_in(rd_sel), .rd_setting_out(rd_setting),
    .filt_state_out(filt), .save_settings_cmd_in(save_cmd), .save_req_out(save_req),
    .save_data_out(save_data), .restore_valid_in(restore_valid),
    .restore_data_in(restore_data),
    .wait_input_level_cmd_in(wait_cmd), .wait_busy_out(wait_busy),
    .wait_done_out(wait_done));
  initial
  begin
    core_clk_in = 1'b0;
    forever #2 core_clk_in = ~core_clk_in;
  end
  always @(posedge core_clk_in)
  begin
    if (sys_rst_in)
      cyc <= 0;
    else
      cyc <= cyc + 1;
  end
  task step(input int n);
    repeat (n) @(posedge core_clk_in);
    #1;
  endtask : step
  task chk(input logic [127:0] got, input logic [127:0] exp);
    compares++;
    if (got !== exp)
    begin
      n_mismatch++;
      $display("FAIL at %0t: got %h expected %h", $time, got, exp);
    end
  endtask : chk
  task write_set(input logic [2:0] sel, input logic [15:0] val);
    set_wr = '{wr: 1'b1, sel: sel, value: val};
    step(1);
  endtask : write_set
  task read_set(input logic [2:0] sel, input logic [15:0] exp);
    rd_sel = sel;
    step(1);
    chk(rd_setting, exp);
  endtask : read_set
  task start_wait(input logic [2:0] sel, input logic lvl);
    wait_cmd = '{start: 1'b1, sel: sel, level: lvl};
    step(1);
    wait_cmd.start = 1'b0;
  endtask : start_wait
  task wait_done_for(input int n);
    int k;
    k = 0;
    while (wait_done !== 1'b1 && k < n)
    begin
      step(1);
      k++;
    end
  endtask : wait_done_for
  task report_and_stop;
    $display("mismatches %0d compares %0d", n_mismatch, compares);
    if (n_mismatch == 0 && compares > 0)
      $display("No errors found");
    else
      $display("Errors were found");
    $finish;
  endtask : report_and_stop
  // two ticks of 25000 cycles, one servo tick of 31250, plus margin
  initial
  begin
    #380000;
    n_mismatch++;
    report_and_stop();
  end
  initial
  begin
    sys_rst_in = 1'b1;
    level = 8'h05;
    set_wr = '0;
    wait_cmd = '0;
    rd_sel = 3'h0;
    save_cmd = 1'b0;
    servo_var = 1'b0;
    volatile_var = 1'b0;
    restore_valid = 1'b0;
    restore_data = 128'h0;
    repeat (4) @(posedge core_clk_in);
    #1;
    sys_rst_in = 1'b0;
    step(12);
    chk(filt, 8'h05);
    for (int i = 0; i < 8; i++)
      read_set(i[2:0], 16'h0000);
    write_set(3'h3, 16'h0002);
    write_set(3'h5, 16'hffff);
    write_set(3'h2, 16'h0001);
    set_wr.wr = 1'b0;
    read_set(3'h2, 16'h0001);
    read_set(3'h3, 16'h0002);
    read_set(3'h5, 16'hffff);
    read_set(3'h4, 16'h0000);
    chk(filt[2], 1'b0);
    start_wait(3'h0, 1'b1);
    chk(wait_done, 1'b1);
    chk(wait_busy, 1'b0);
    save_cmd = 1'b1;
    step(1);
    save_cmd = 1'b0;
    chk(save_req, 1'b1);
    chk(save_data, (128'hffff << 80) | (128'h2 << 48) | (128'h1 << 32));
    level = 8'h0d;
    start_wait(3'h3, 1'b1);
    step(1);
    chk(wait_busy, 1'b1);
    while (cyc < 37500)
      step(1);
    chk(filt[3], 1'b0);
    chk(filt[2], 1'b1);
    chk(wait_busy, 1'b1);
    wait_done_for(15000);
    chk(wait_done, 1'b1);
    chk(filt[3], 1'b1);
    chk(cyc >= 49992 && cyc <= 50010, 1'b1);
    chk(filt[5], 1'b0);
    chk(filt[2], 1'b1);
    // mid-run reset as a volatile servo variant
    sys_rst_in = 1'b1;
    servo_var = 1'b1;
    volatile_var = 1'b1;
    level = 8'h02;
    step(2);
    sys_rst_in = 1'b0;
    save_cmd = 1'b1;
    step(1);
    save_cmd = 1'b0;
    chk(save_req, 1'b0);
    restore_valid = 1'b1;
    restore_data = 128'h1 << 16;
    step(1);
    restore_valid = 1'b0;
    read_set(3'h1, 16'h0000);
    // reset again as a non-volatile servo variant
    sys_rst_in = 1'b1;
    volatile_var = 1'b0;
    step(2);
    sys_rst_in = 1'b0;
    restore_valid = 1'b1;
    step(1);
    restore_valid = 1'b0;
    read_set(3'h1, 16'h0001);
    chk(filt[1], 1'b0);
    while (cyc < 31240)
      step(1);
    chk(filt[1], 1'b0);
    while (filt[1] !== 1'b1 && cyc < 31300)
      step(1);
    chk(filt[1], 1'b1);
    chk(cyc >= 31245 && cyc <= 31260, 1'b1);
    report_and_stop();
  end
endmodule : tb
`default_nettype wire
